// ===== include/rdm_pkg.sv
// package: offsets, field positions, reset values and decode helpers of the mode registers
package rdm_pkg;
  // register offsets, also the byte addresses seen by the serial engine
  localparam logic [7:0] OFS_GENERAL = 8'h0a;
  localparam logic [7:0] OFS_DBG_TX = 8'h0b;
  localparam logic [7:0] OFS_DP01_EQ = 8'h10;
  localparam logic [7:0] OFS_DP23_EQ = 8'h11;
  localparam logic [7:0] OFS_AUX_STAT = 8'h12;
  localparam logic [7:0] OFS_DP_LANE_EN = 8'h13;
  localparam logic [7:0] OFS_AEQ_CTL_A = 8'h1c;
  localparam logic [7:0] OFS_AEQ_CTL_B = 8'h1d;
  localparam logic [7:0] OFS_ADAPTIVE_EQ_LONG_CHANNEL = 8'h1e;
  localparam logic [7:0] OFS_CONN_EQ = 8'h20;
  localparam logic [7:0] OFS_SUPERSPEED_TX_RECEIVER_EQUALIZER = 8'h21;
  localparam logic [7:0] OFS_USB3_MISCELLANEOUS_CONTROL = 8'h22;
  localparam logic [7:0] OFS_USB_STAT = 8'h24;
  localparam logic [7:0] OFS_SWING_CTL = 8'h32;
  localparam logic [7:0] OFS_AEQ_STAT = 8'h3b;

  // general_mode_control field positions
  localparam int BIT_LIMITED = 7;
  localparam int BIT_RSVD = 6;
  localparam int BIT_HP_SWAP = 5;
  localparam int BIT_EQ_REGS = 4;
  localparam int BIT_HP_FORCE = 3;
  localparam int BIT_FLIP = 2;
  localparam int LSB_LANE_MODE = 0;

  // reset and write-mask values
  localparam logic [7:0] RST_GENERAL = 8'h01;
  localparam logic [7:0] MASK_GENERAL = 8'hbf;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_DBG_TX = 8'h6c;

  // lane modes
  localparam logic [1:0] LANE_OFF = 2'h0;
  localparam logic [1:0] LANE_USB3 = 2'h1;
  localparam logic [1:0] LANE_DP4 = 2'h2;
  localparam logic [1:0] LANE_USB3_DP2 = 2'h3;

  // cycles the strap synchroniser needs before the pins are trusted
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  // plain read/write storage held in the little memory
  function automatic logic is_mem_ofs(input logic [7:0] ofs);
    case (ofs)
      OFS_DBG_TX, OFS_DP_LANE_EN, OFS_AEQ_CTL_A, OFS_AEQ_CTL_B, OFS_ADAPTIVE_EQ_LONG_CHANNEL,
      OFS_CONN_EQ, OFS_SUPERSPEED_TX_RECEIVER_EQUALIZER, OFS_USB3_MISCELLANEOUS_CONTROL, OFS_SWING_CTL: is_mem_ofs = 1'b1;
      default: is_mem_ofs = 1'b0;
    endcase
  endfunction

  // read-only status locations
  function automatic logic is_stat_ofs(input logic [7:0] ofs);
    is_stat_ofs = (ofs == OFS_AUX_STAT) || (ofs == OFS_USB_STAT) || (ofs == OFS_AEQ_STAT);
  endfunction

  // any location that appears in the map
  function automatic logic is_mapped(input logic [7:0] ofs);
    is_mapped = is_mem_ofs(ofs) || is_stat_ofs(ofs) || (ofs == OFS_GENERAL) ||
                (ofs == OFS_DP01_EQ) || (ofs == OFS_DP23_EQ);
  endfunction

  // two lanes of equalizer setting taken from the two strap pins
  function automatic logic [7:0] eq_pin_byte(input logic [1:0] pins);
    eq_pin_byte = {2'h0, pins, 2'h0, pins};
  endfunction
endpackage

// ===== rtl/rdm_reg_mem.sv
// small storage for the plain read/write mode registers, registered read data
module rdm_reg_mem (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // write port
  input wire logic i_we,
  input wire logic [5:0] i_waddr,
  input wire logic [7:0] i_wdata,
  // read port
  input wire logic [5:0] i_raddr,
  output logic [7:0] o_rdata
);
  typedef struct packed {
    logic [63:0][7:0] mem;
    logic [7:0] rdata;
  } rdm_mem_t;

  rdm_mem_t st_r;
  rdm_mem_t st_nxt;

  // read returns the old word when a write hits the same address
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = st_r.mem[i_raddr];
    if (i_we) begin
      st_nxt.mem[i_waddr] = i_wdata;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_r <= '0;
      // the transmit shaping byte wakes up with its own non-zero default
      st_r.mem[rdm_pkg::OFS_DBG_TX[5:0]] <= rdm_pkg::RST_DBG_TX;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_rdata = st_r.rdata;
endmodule // rdm_reg_mem

// ===== rtl/rdm_mode_regs.sv
// mode control register bank of the redriver crosspoint switch
module rdm_mode_regs (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // byte port from the serial target engine
  input wire logic i_ofs_valid,
  input wire logic [7:0] i_ofs,
  input wire logic i_wr_valid,
  input wire logic [7:0] i_wr_data,
  input wire logic i_rd_req,
  output logic o_rd_valid,
  output logic [7:0] o_rd_data,
  // device pins, asynchronous
  input wire logic i_hotplug_input_a,
  input wire logic i_hotplug_input_b,
  input wire logic [1:0] i_display_equalizer_pins,
  // hardware status from the datapath, same clock
  input wire logic [7:0] i_aux_snoop_status,
  input wire logic [7:0] i_usb_sm_status,
  input wire logic [7:0] i_adaptive_eq_status,
  // controls to the mux and equalizers
  output logic [1:0] o_lane_mode_select,
  output logic o_flip_orientation,
  output logic o_limited_redrive_select,
  output logic o_hotplug_internal,
  output logic o_closed_chassis_debug_disable,
  output logic o_register_equalizer_select,
  output logic [15:0] o_dp_lane_equalizer
);
  typedef struct packed {
    // pin synchronisers, stage 1 feeds stage 2 only
    logic hpa_s1;
    logic hpa_s2;
    logic hpa_s3;
    logic hpb_s1;
    logic hpb_s2;
    logic hpb_s3;
    logic [1:0] eq_s1;
    logic [1:0] eq_s2;
    logic [1:0] eq_s3;
    logic hpa_stable;
    logic hpb_stable;
    logic [1:0] eq_stable;
    // equalizer strap capture
    logic [1:0] strap_cnt;
    logic strap_done;
    logic [1:0] eq_strap;
    // registers held here because they steer the outputs
    logic [7:0] gen;
    logic [7:0] eq01;
    logic [7:0] eq23;
    logic [7:0] ptr;
    // read pipeline
    logic rd_d1;
    logic from_mem_d1;
    logic [7:0] pre_d1;
    logic rd_valid;
    logic [7:0] rd_data;
    // control outputs
    logic [1:0] lane_mode;
    logic flip;
    logic limited;
    logic hp_int;
    logic dci_dis;
    logic eq_regs;
    logic [15:0] eq_lanes;
  } rdm_state_t;

  rdm_state_t st_r;
  rdm_state_t st_nxt;
  logic mem_we;
  logic [7:0] mem_rdata;

  // plain storage locations live in a separate memory
  rdm_reg_mem u_mem (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_we(mem_we),
    .i_waddr(st_r.ptr[5:0]),
    .i_wdata(i_wr_data),
    .i_raddr(st_r.ptr[5:0]),
    .o_rdata(mem_rdata)
  );

  // byte writes that land in the memory; everything unmapped is dropped
  assign mem_we = i_wr_valid && !i_ofs_valid && rdm_pkg::is_mem_ofs(st_r.ptr);

  // next-state logic: sync, strap, register access, read pipe, controls
  always_comb begin
    logic [7:0] eq01_view;
    logic [7:0] eq23_view;
    logic hp_pin;
    st_nxt = st_r;
    eq01_view = 8'h00;
    eq23_view = 8'h00;
    hp_pin = 1'b0;

    // three-stage synchronisers; a level counts once stages 2 and 3 agree
    st_nxt.hpa_s1 = i_hotplug_input_a;
    st_nxt.hpa_s2 = st_r.hpa_s1;
    st_nxt.hpa_s3 = st_r.hpa_s2;
    st_nxt.hpb_s1 = i_hotplug_input_b;
    st_nxt.hpb_s2 = st_r.hpb_s1;
    st_nxt.hpb_s3 = st_r.hpb_s2;
    st_nxt.eq_s1 = i_display_equalizer_pins;
    st_nxt.eq_s2 = st_r.eq_s1;
    st_nxt.eq_s3 = st_r.eq_s2;
    if (st_r.hpa_s2 == st_r.hpa_s3) begin
      st_nxt.hpa_stable = st_r.hpa_s3;
    end
    if (st_r.hpb_s2 == st_r.hpb_s3) begin
      st_nxt.hpb_stable = st_r.hpb_s3;
    end
    if (st_r.eq_s2 == st_r.eq_s3) begin
      st_nxt.eq_stable = st_r.eq_s3;
    end

    // straps are caught once, after the synchroniser has filled
    if (!st_r.strap_done) begin
      if (st_r.strap_cnt == rdm_pkg::STRAP_WAIT) begin
        st_nxt.strap_done = 1'b1;
        // take the level settling at this edge; the stored copy still holds reset zero
        st_nxt.eq_strap = st_nxt.eq_stable;
      end else begin
        st_nxt.strap_cnt = st_r.strap_cnt + 2'h1;
      end
    end

    // equalizer fields follow the straps until register select is set
    if (st_r.gen[rdm_pkg::BIT_EQ_REGS]) begin
      eq01_view = st_r.eq01;
      eq23_view = st_r.eq23;
    end else begin
      eq01_view = rdm_pkg::eq_pin_byte(st_r.eq_strap);
      eq23_view = rdm_pkg::eq_pin_byte(st_r.eq_strap);
    end

    // byte port: offset load wins, then write, then read
    st_nxt.rd_d1 = 1'b0;
    if (i_ofs_valid) begin
      st_nxt.ptr = i_ofs;
    end else if (i_wr_valid) begin
      if (st_r.ptr == rdm_pkg::OFS_GENERAL) begin
        st_nxt.gen = i_wr_data & rdm_pkg::MASK_GENERAL;
      end else if (st_r.ptr == rdm_pkg::OFS_DP01_EQ) begin
        st_nxt.eq01 = i_wr_data;
      end else if (st_r.ptr == rdm_pkg::OFS_DP23_EQ) begin
        st_nxt.eq23 = i_wr_data;
      end
      st_nxt.ptr = st_r.ptr + 8'h01;
    end else if (i_rd_req) begin
      // the pointer moves on whatever the host answers to the byte
      st_nxt.ptr = st_r.ptr + 8'h01;
      st_nxt.rd_d1 = 1'b1;
      st_nxt.from_mem_d1 = rdm_pkg::is_mem_ofs(st_r.ptr);
      case (st_r.ptr)
        rdm_pkg::OFS_GENERAL: st_nxt.pre_d1 = st_r.gen;
        rdm_pkg::OFS_DP01_EQ: st_nxt.pre_d1 = eq01_view;
        rdm_pkg::OFS_DP23_EQ: st_nxt.pre_d1 = eq23_view;
        rdm_pkg::OFS_AUX_STAT: st_nxt.pre_d1 = i_aux_snoop_status;
        rdm_pkg::OFS_USB_STAT: st_nxt.pre_d1 = i_usb_sm_status;
        rdm_pkg::OFS_AEQ_STAT: st_nxt.pre_d1 = i_adaptive_eq_status;
        default: st_nxt.pre_d1 = 8'h00;
      endcase
    end

    // second read stage: memory word arrives one cycle after the request
    st_nxt.rd_valid = st_r.rd_d1;
    if (st_r.rd_d1) begin
      st_nxt.rd_data = st_r.from_mem_d1 ? mem_rdata : st_r.pre_d1;
    end

    // controls come from the next register value so they move with the write
    st_nxt.lane_mode = st_nxt.gen[rdm_pkg::LSB_LANE_MODE +: 2];
    st_nxt.flip = st_nxt.gen[rdm_pkg::BIT_FLIP];
    st_nxt.limited = st_nxt.gen[rdm_pkg::BIT_LIMITED];
    st_nxt.eq_regs = st_nxt.gen[rdm_pkg::BIT_EQ_REGS];
    // the swap reroutes the debug pin, so debug must be off while it is set
    st_nxt.dci_dis = st_nxt.gen[rdm_pkg::BIT_HP_SWAP];
    hp_pin = st_nxt.gen[rdm_pkg::BIT_HP_SWAP] ? st_r.hpb_stable : st_r.hpa_stable;
    st_nxt.hp_int = st_nxt.gen[rdm_pkg::BIT_HP_FORCE] | hp_pin;
    if (st_nxt.gen[rdm_pkg::BIT_EQ_REGS]) begin
      st_nxt.eq_lanes = {st_nxt.eq23, st_nxt.eq01};
    end else begin
      st_nxt.eq_lanes = {rdm_pkg::eq_pin_byte(st_r.eq_strap),
                         rdm_pkg::eq_pin_byte(st_r.eq_strap)};
    end
  end

  // state register; general register starts in usb3-only mode
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_r <= '0;
      st_r.gen <= rdm_pkg::RST_GENERAL;
      st_r.lane_mode <= rdm_pkg::LANE_USB3;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state flops
  assign o_rd_valid = st_r.rd_valid;
  assign o_rd_data = st_r.rd_data;
  assign o_lane_mode_select = st_r.lane_mode;
  assign o_flip_orientation = st_r.flip;
  assign o_limited_redrive_select = st_r.limited;
  assign o_hotplug_internal = st_r.hp_int;
  assign o_closed_chassis_debug_disable = st_r.dci_dis;
  assign o_register_equalizer_select = st_r.eq_regs;
  assign o_dp_lane_equalizer = st_r.eq_lanes;

  // checks: helper flag marks that the general register has been written
  logic gen_written_r;
  logic gen_wr;
  assign gen_wr = i_wr_valid && !i_ofs_valid && (st_r.ptr == rdm_pkg::OFS_GENERAL);
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      gen_written_r <= 1'b0;
    end else if (gen_wr) begin
      gen_written_r <= 1'b1;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // reset image holds until software writes the register
  property p_reset_image;
    !gen_written_r && !gen_wr |=> (o_lane_mode_select == 2'h1) && !o_flip_orientation &&
      !o_limited_redrive_select && !o_register_equalizer_select;
  endproperty
  a_reset_image: assert property (p_reset_image)
    else $error("general register left its reset image without a write");

  // lane mode follows the written byte one cycle later
  property p_lane_mode;
    gen_wr |=> o_lane_mode_select == $past(i_wr_data[1:0]);
  endproperty
  a_lane_mode: assert property (p_lane_mode)
    else $error("lane mode did not follow the general register write");

  // orientation and redrive style follow the write together
  property p_flip_limit;
    gen_wr |=> (o_flip_orientation == $past(i_wr_data[2])) &&
      (o_limited_redrive_select == $past(i_wr_data[7]));
  endproperty
  a_flip_limit: assert property (p_flip_limit)
    else $error("orientation or redrive style wrong after write");

  // equalizer source select follows bit 4
  property p_eq_source;
    gen_wr |=> o_register_equalizer_select == $past(i_wr_data[4]);
  endproperty
  a_eq_source: assert property (p_eq_source)
    else $error("equalizer source select wrong after write");

  // swap bit drives debug disable
  property p_dci_off;
    gen_wr && i_wr_data[5] |=> o_closed_chassis_debug_disable;
  endproperty
  a_dci_off: assert property (p_dci_off)
    else $error("debug function still enabled while hot-plug swap set");

  // forced hot-plug is high in the cycle after the force bit is written
  property p_hp_force;
    gen_wr && i_wr_data[rdm_pkg::BIT_HP_FORCE] |=> o_hotplug_internal;
  endproperty
  a_hp_force: assert property (p_hp_force)
    else $error("hot-plug not forced high");

  // pointer moves by one on every read byte
  property p_ptr_step;
    i_rd_req && !i_ofs_valid && !i_wr_valid |=> st_r.ptr == $past(st_r.ptr) + 8'h01;
  endproperty
  a_ptr_step: assert property (p_ptr_step)
    else $error("read pointer did not advance");

  // unmapped reads answer zero two cycles later
  property p_unmapped_zero;
    i_rd_req && !i_ofs_valid && !i_wr_valid && !rdm_pkg::is_mapped(st_r.ptr)
      |-> ##2 o_rd_valid && (o_rd_data == 8'h00);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped offset returned nonzero data");

  // reserved bit reads zero in the general register
  property p_rsvd_zero;
    i_rd_req && !i_ofs_valid && !i_wr_valid && (st_r.ptr == rdm_pkg::OFS_GENERAL)
      |-> ##2 o_rd_valid && !o_rd_data[6];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved bit of general register read as one");

  // equalizer field reads the strap while register select is off
  property p_eq_pin_view;
    i_rd_req && !i_ofs_valid && !i_wr_valid && (st_r.ptr == rdm_pkg::OFS_DP01_EQ) &&
      !st_r.gen[4] |-> ##2 o_rd_data == {2'h0, $past(st_r.eq_strap, 2), 2'h0,
      $past(st_r.eq_strap, 2)};
  endproperty
  a_eq_pin_view: assert property (p_eq_pin_view)
    else $error("equalizer field did not show the sampled pins");

  // internal hot-plug stays high for as long as the force bit is held
  property p_hp_hold;
    st_r.gen[rdm_pkg::BIT_HP_FORCE] |-> o_hotplug_internal;
  endproperty
  a_hp_hold: assert property (p_hp_hold)
    else $error("hot-plug dropped while the force bit is set");

  // without force the internal hot-plug tracks the pin picked by the swap bit
  property p_hp_source;
    !st_r.gen[rdm_pkg::BIT_HP_FORCE] |-> o_hotplug_internal ==
      (st_r.gen[rdm_pkg::BIT_HP_SWAP] ? $past(st_r.hpb_stable) : $past(st_r.hpa_stable));
  endproperty
  a_hp_source: assert property (p_hp_source)
    else $error("hot-plug followed the wrong pin");

  // the aux status location answers with the live input taken at the request edge
  property p_status_live;
    i_rd_req && !i_ofs_valid && !i_wr_valid && (st_r.ptr == rdm_pkg::OFS_AUX_STAT)
      |-> ##2 o_rd_valid && (o_rd_data == $past(i_aux_snoop_status, 2));
  endproperty
  a_status_live: assert property (p_status_live)
    else $error("status read did not return the live hardware value");

  // with register select on, the lane equalizers show the stored bytes
  property p_eq_regs_lanes;
    o_register_equalizer_select |-> o_dp_lane_equalizer == {st_r.eq23, st_r.eq01};
  endproperty
  a_eq_regs_lanes: assert property (p_eq_regs_lanes)
    else $error("lane equalizers ignored the register bytes");
endmodule // rdm_mode_regs

// ===== dv/rdm_host_model.sv
// host-side model of the serial target engine driving the byte port of the mode registers
module rdm_host_model (
  // clock
  input wire logic i_clk,
  // byte port towards the register bank
  output logic o_ofs_valid,
  output logic [7:0] o_ofs,
  output logic o_wr_valid,
  output logic [7:0] o_wr_data,
  output logic o_rd_req,
  // read answer from the register bank
  input wire logic i_rd_valid,
  input wire logic [7:0] i_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle port at time zero
  initial begin
    o_ofs_valid = 1'b0;
    o_ofs = 8'h00;
    o_wr_valid = 1'b0;
    o_wr_data = 8'h00;
    o_rd_req = 1'b0;
  end

  // pointer load; buses are inverted once released so a stale byte never looks valid
  task automatic put_ofs(input logic [7:0] a);
    @(posedge i_clk);
    o_ofs_valid <= 1'b1;
    o_ofs <= a;
    @(posedge i_clk);
    o_ofs_valid <= 1'b0;
    o_ofs <= ~a;
  endtask

  // offset then one data byte; only the refusal case touches reserved offsets
  // and the swap bit is only set where debug support is not wanted
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    put_ofs(a);
    o_wr_valid <= 1'b1;
    o_wr_data <= d;
    @(posedge i_clk);
    o_wr_valid <= 1'b0;
    o_wr_data <= ~d;
  endtask

  // one read byte from the current pointer, answer awaited under a bound
  task automatic rd_pulse(output logic [7:0] d);
    int n;
    o_rd_req <= 1'b1;
    @(posedge i_clk);
    o_rd_req <= 1'b0;
    n = 0;
    // look between edges, where the registered answer has settled
    @(negedge i_clk);
    while (i_rd_valid !== 1'b1 && n < 8) begin
      @(negedge i_clk);
      n++;
    end
    d = (n < 8) ? i_rd_data : 8'hxx;
  endtask

  // read continuing at the auto-incremented pointer
  task automatic rd_next(output logic [7:0] d);
    @(posedge i_clk);
    rd_pulse(d);
  endtask

  // read with a fresh offset, as a repeated-start read does
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    put_ofs(a);
    rd_pulse(d);
  endtask
endmodule // rdm_host_model

// ===== dv/rdm_mode_regs_tb.sv
// self-checking testbench of the mode control register bank
module rdm_mode_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic i_clk, i_sys_rst, ofs_valid, wr_valid, rd_req, rd_valid;
  logic [7:0] ofs, wr_data, rd_data, aux_st, usb_st, aeq_st;
  logic hp_a, hp_b, lim, flip, hp_int, ccd_dis, reg_eq;
  logic [1:0] eq_pins, lane;
  logic [15:0] dp_eq;
  logic [7:0] d;
  int n_mismatch, samples_checked;
  logic [7:0] modes [8] = '{8'h90, 8'h95, 8'h92, 8'h96, 8'h93, 8'h97, 8'h7e, 8'h01};

  // 250 MHz clock
  always #2 i_clk = ~i_clk;

  rdm_host_model host (.i_clk(i_clk), .o_ofs_valid(ofs_valid), .o_ofs(ofs),
    .o_wr_valid(wr_valid), .o_wr_data(wr_data), .o_rd_req(rd_req),
    .i_rd_valid(rd_valid), .i_rd_data(rd_data));

  rdm_mode_regs DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ofs_valid(ofs_valid),
    .i_ofs(ofs), .i_wr_valid(wr_valid), .i_wr_data(wr_data), .i_rd_req(rd_req),
    .o_rd_valid(rd_valid), .o_rd_data(rd_data), .i_hotplug_input_a(hp_a),
    .i_hotplug_input_b(hp_b), .i_display_equalizer_pins(eq_pins),
    .i_aux_snoop_status(aux_st), .i_usb_sm_status(usb_st), .i_adaptive_eq_status(aeq_st),
    .o_lane_mode_select(lane), .o_flip_orientation(flip),
    .o_limited_redrive_select(lim), .o_hotplug_internal(hp_int),
    .o_closed_chassis_debug_disable(ccd_dis), .o_register_equalizer_select(reg_eq),
    .o_dp_lane_equalizer(dp_eq));

  // single compare for every result, widened to 16 bits
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // verdict and end of run
  task automatic report_and_stop();
    $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // control outputs packed as lane mode, flip, limited, debug disable and register select
  function automatic logic [15:0] ctl();
    return {10'h0, lane, flip, lim, ccd_dis, reg_eq};
  endfunction
  function automatic logic [15:0] exp_ctl(input logic [7:0] v);
    return {10'h0, v[1:0], v[2], v[7], v[5], v[4]};
  endfunction

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    host.rd_reg(a, d);
    chk({8'h0, d}, {8'h0, exp});
  endtask

  // general write, controls looked at in the very next cycle
  task automatic wr_gen(input logic [7:0] v);
    host.wr_reg(8'h0a, v);
    @(negedge i_clk);
    chk(ctl(), exp_ctl(v));
  endtask

  // hot-plug goes through a pin synchroniser, so allow a short bounded settle
  task automatic wait_hp(input logic e);
    int n;
    n = 0;
    while (hp_int !== e && n < 12) begin
      @(negedge i_clk);
      n++;
    end
    chk({15'h0, hp_int}, {15'h0, e});
  endtask

  task automatic do_reset();
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
  endtask

  // main sequence
  initial begin
    i_clk = 1'b0;
    i_sys_rst = 1'b1;
    hp_a = 1'b1;
    hp_b = 1'b0;
    eq_pins = 2'h2;
    aux_st = 8'h3c;
    usb_st = 8'h5a;
    aeq_st = 8'h81;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    // strap capture needs a few edges after release
    repeat (6) @(posedge i_clk);
    @(negedge i_clk);
    chk(ctl(), exp_ctl(8'h01));
    rd_chk(8'h0a, 8'h01);
    rd_chk(8'h10, 8'h22);
    chk(dp_eq, 16'h2222);
    host.wr_reg(8'h10, 8'h5a);
    host.wr_reg(8'h11, 8'ha5);
    rd_chk(8'h10, 8'h22);
    chk(dp_eq, 16'h2222);
    wr_gen(8'h11);
    rd_chk(8'h10, 8'h5a);
    host.rd_next(d);
    chk({8'h0, d}, 16'h00a5);
    chk(dp_eq, 16'ha55a);
    // every lane mode, both orientations, limited and linear, reserved bit dropped
    foreach (modes[i]) begin
      wr_gen(modes[i]);
      rd_chk(8'h0a, modes[i] & 8'hbf);
    end
    // hot-plug source, swap side effect and force
    wait_hp(1'b1);
    wr_gen(8'h21);
    wait_hp(1'b0);
    wr_gen(8'h29);
    wait_hp(1'b1);
    wr_gen(8'h21);
    @(posedge i_clk);
    hp_a <= 1'b0;
    hp_b <= 1'b1;
    wait_hp(1'b1);
    wr_gen(8'h01);
    wait_hp(1'b0);
    // plain register read by auto-increment after general
    host.wr_reg(8'h0b, 8'h93);
    rd_chk(8'h0a, 8'h01);
    host.rd_next(d);
    chk({8'h0, d}, 16'h0093);
    // hardware-updated status read live, writes ignored
    rd_chk(8'h12, 8'h3c);
    host.wr_reg(8'h12, 8'hff);
    @(posedge i_clk);
    aux_st <= 8'hc3;
    rd_chk(8'h12, 8'hc3);
    rd_chk(8'h24, 8'h5a);
    rd_chk(8'h3b, 8'h81);
    // reserved offset: write dropped, reads zero
    host.wr_reg(8'h05, 8'haa);
    rd_chk(8'h05, 8'h00);
    // an unlisted offset whose low bits alias a stored byte must not reach it
    host.wr_reg(8'h4b, 8'h55);
    rd_chk(8'h4b, 8'h00);
    rd_chk(8'h0b, 8'h93);
    // second reset in mid-run brings the defaults back
    do_reset();
    @(negedge i_clk);
    chk(ctl(), exp_ctl(8'h01));
    rd_chk(8'h0a, 8'h01);
    rd_chk(8'h0b, 8'h6c);
    report_and_stop();
  end

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #(5000 * 4);
    n_mismatch++;
    report_and_stop();
  end
endmodule // rdm_mode_regs_tb
